// File: sotf_consts.vh
// Constants for the capacity warning and load model block.
// Assumes inclusion by the single design file.
`ifndef SOTF_CONSTS_VH
`define SOTF_CONSTS_VH
`define SOTF_ADDR_W        4
`define SOTF_DATA_W        32
`define SOTF_OFF_CFG       4'h0
`define SOTF_OFF_SOC_INITIAL_WARN_FLAG_THR  4'h1
`define SOTF_OFF_SOC_FINAL_WARN_FLAG_THR  4'h2
`define SOTF_OFF_DSG_THR   4'h3
`define SOTF_OFF_FLAGS     4'h4
`define SOTF_OFF_CAP       4'h5
`define SOTF_OFF_LOAD      4'h6
`define SOTF_OFF_INT_STAT  4'h7
`define SOTF_OFF_INT_MASK  4'h8
`define SOTF_OFF_ENERGY    4'h9
`define SOTF_OFF_USER_RATE 4'ha
`define SOTF_CFG_LOAD_MODEL_STATUS_BIT      0
`define SOTF_CFG_RESERVE_COMP_SELECT    1
`define SOTF_CFG_SCALE10   2
`define SOTF_CFG_LSEL_LO   4
`define SOTF_CFG_RESET     32'h0000_0010
`define SOTF_SOC_INITIAL_WARN_FLAG_RESET    32'h0096_00c8
`define SOTF_SOC_FINAL_WARN_FLAG_RESET    32'h0064_0032
`define SOTF_DSG_RESET     32'h0000_003c
`define SOTF_FLG_SOC_INITIAL_WARN_FLAG      0
`define SOTF_FLG_SOC_FINAL_WARN_FLAG      1
`define SOTF_FLG_ISD       2
`define SOTF_FLG_TDD       3
`define SOTF_FLG_DSG       4
`define SOTF_FLG_LOAD_MODEL_STATUS_BIT      5
`define SOTF_SOC_FINAL_WARN_FLAG_OFF      16'hffff
`endif

// File: sotf_core.v
// Capacity warning flags, load model select, reserve compensation and scale.
// Assumes synchronous inputs from the gauge datapath and a simple register port.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sotf_consts.vh"
// How it works
// - Integrate sense charge into remaining capacity
// - Full capacity is loaded, until termination
// - Nominal and full available are unloaded
// - Set initial warning below set threshold
// - Clear initial warning above clear threshold
// - Set final warning below final threshold
// - Final threshold minus one disables setting
// - Clear final only when set, above clear
// - Relaxed voltage check flags internal short
// - Two-cell parallel tab disconnect flag
// - Load model zero current, one power
// - Load model mirrored into status word
// - Current mode load select chooses rate
// - Power mode load select chooses rate
// - Reserve compensation loaded or no-load select
// - Scale ten uses centi units, trise
// - Discharge threshold decides true discharge
module sotf_core #(
  parameter CAP_W = 16
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_reset,
  // Register port
  input  wire [3:0]       i_addr,
  input  wire [31:0]      i_wdata,
  input  wire             i_wr,
  input  wire             i_rd,
  output reg  [31:0]      o_rdata,
  // Gauge datapath inputs
  input  wire             i_cap_update,
  input  wire signed [CAP_W-1:0] i_charge_delta,
  input  wire signed [CAP_W-1:0] i_current,
  input  wire [CAP_W-1:0] i_full_loaded,
  input  wire [CAP_W-1:0] i_full_unloaded,
  input  wire [CAP_W-1:0] i_volt_mv,
  input  wire [CAP_W-1:0] i_term_mv,
  input  wire [CAP_W-1:0] i_reserve_loaded,
  input  wire [CAP_W-1:0] i_reserve_noload,
  input  wire             i_relaxed,
  input  wire             i_short_detect,
  input  wire             i_two_cell_par,
  input  wire             i_tab_detect,
  // Load model rate sources
  input  wire [CAP_W-1:0] i_rate_prev,
  input  wire [CAP_W-1:0] i_rate_present,
  input  wire [CAP_W-1:0] i_rate_avg,
  input  wire [CAP_W-1:0] i_rate_filt,
  input  wire [CAP_W-1:0] i_rate_design5,
  input  wire [CAP_W-1:0] i_forecast_rate_value,
  // Results
  output reg  [CAP_W-1:0] o_remaining_cap,
  output reg  [CAP_W-1:0] o_full_charge_cap,
  output reg  [CAP_W-1:0] o_nominal_avail_cap,
  output reg  [CAP_W-1:0] o_full_avail_cap,
  output reg  [CAP_W-1:0] o_load_rate,
  output reg  [CAP_W-1:0] o_reserve_cap,
  output reg              o_soc_initial_warn_flag,
  output reg              o_soc_final_warn_flag,
  output reg              o_internal_short_flag,
  output reg              o_tab_disconnect_flag,
  output reg              o_discharging,
  output reg              o_load_model_status_bit,
  output reg              o_scale_x10,
  output reg              o_irq
);

  // Config and threshold registers
  reg [31:0] cfg_reg;
  reg [31:0] soc_initial_warn_flag_thr_reg;
  reg [31:0] soc_final_warn_flag_thr_reg;
  reg [31:0] dsg_thr_reg;
  reg [31:0] user_rate_reg;
  reg [31:0] energy_reg;
  reg [5:0]  int_stat_reg;
  reg [5:0]  int_mask_reg;
  reg [CAP_W-1:0] nom_reg;

  wire        load_model    = cfg_reg[`SOTF_CFG_LOAD_MODEL_STATUS_BIT];
  wire        reserve_comp_select = cfg_reg[`SOTF_CFG_RESERVE_COMP_SELECT];
  wire [2:0]  load_sel      = cfg_reg[`SOTF_CFG_LSEL_LO+2:`SOTF_CFG_LSEL_LO];
  wire [CAP_W-1:0] soc_initial_warn_flag_set  = soc_initial_warn_flag_thr_reg[CAP_W-1:0];
  wire [CAP_W-1:0] soc_initial_warn_flag_clr  = soc_initial_warn_flag_thr_reg[CAP_W+15:16];
  wire [CAP_W-1:0] soc_final_warn_flag_set  = soc_final_warn_flag_thr_reg[CAP_W-1:0];
  wire [CAP_W-1:0] soc_final_warn_flag_clr  = soc_final_warn_flag_thr_reg[CAP_W+15:16];
  wire signed [CAP_W-1:0] dsg_thr = dsg_thr_reg[CAP_W-1:0];

  // Next remaining capacity, saturated at both ends
  wire signed [CAP_W+1:0] rc_sum = $signed({2'b00, o_remaining_cap}) + i_charge_delta;
  wire [CAP_W-1:0] rc_next = rc_sum[CAP_W+1] ? {CAP_W{1'b0}} :
                             (rc_sum[CAP_W] ? {CAP_W{1'b1}} : rc_sum[CAP_W-1:0]);
  wire signed [CAP_W+1:0] nom_sum = $signed({2'b00, nom_reg}) + i_charge_delta;
  wire [CAP_W-1:0] nom_next = nom_sum[CAP_W+1] ? {CAP_W{1'b0}} :
                              (nom_sum[CAP_W] ? {CAP_W{1'b1}} : nom_sum[CAP_W-1:0]);

  // Rate chosen by load select; same table for both models
  function [CAP_W-1:0] pick_rate;
    input [2:0]       sel;
    input [CAP_W-1:0] user;
    begin
      case (sel)
        3'h0:    pick_rate = i_rate_prev;
        3'h1:    pick_rate = i_rate_present;
        3'h2:    pick_rate = i_rate_avg;
        3'h3:    pick_rate = i_rate_filt;
        3'h4:    pick_rate = i_rate_design5;
        3'h5:    pick_rate = i_forecast_rate_value;
        default: pick_rate = user;
      endcase
    end
  endfunction

  wire [5:0] events = {1'b0, ~o_discharging & (i_current < -dsg_thr),
                       i_tab_detect & i_two_cell_par & ~o_tab_disconnect_flag,
                       i_relaxed & i_short_detect & ~o_internal_short_flag,
                       1'b0, 1'b0};
  wire [5:0] soc_evt;
  assign soc_evt[0] = i_cap_update & ~o_soc_initial_warn_flag & (rc_next < soc_initial_warn_flag_set);
  assign soc_evt[1] = i_cap_update & ~o_soc_final_warn_flag & (soc_final_warn_flag_set != `SOTF_SOC_FINAL_WARN_FLAG_OFF) & (rc_next < soc_final_warn_flag_set);
  assign soc_evt[5:2] = events[5:2];

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg_reg       <= `SOTF_CFG_RESET;
      soc_initial_warn_flag_thr_reg  <= `SOTF_SOC_INITIAL_WARN_FLAG_RESET;
      soc_final_warn_flag_thr_reg  <= `SOTF_SOC_FINAL_WARN_FLAG_RESET;
      dsg_thr_reg   <= `SOTF_DSG_RESET;
      user_rate_reg <= 32'h0000_0000;
      energy_reg    <= 32'h0000_0000;
      int_mask_reg  <= 6'h00;
      int_stat_reg  <= 6'h00;
      nom_reg       <= {CAP_W{1'b0}};
      o_rdata       <= 32'h0000_0000;
      o_remaining_cap         <= {CAP_W{1'b0}};
      o_full_charge_cap       <= {CAP_W{1'b0}};
      o_nominal_avail_cap     <= {CAP_W{1'b0}};
      o_full_avail_cap        <= {CAP_W{1'b0}};
      o_load_rate             <= {CAP_W{1'b0}};
      o_reserve_cap           <= {CAP_W{1'b0}};
      o_soc_initial_warn_flag <= 1'b0;
      o_soc_final_warn_flag   <= 1'b0;
      o_internal_short_flag   <= 1'b0;
      o_tab_disconnect_flag   <= 1'b0;
      o_discharging           <= 1'b0;
      o_load_model_status_bit <= 1'b0;
      o_scale_x10             <= 1'b0;
      o_irq                   <= 1'b0;
    end else begin
      // Register writes
      if (i_wr) begin
        case (i_addr)
          `SOTF_OFF_CFG:       cfg_reg       <= i_wdata;
          `SOTF_OFF_SOC_INITIAL_WARN_FLAG_THR:  soc_initial_warn_flag_thr_reg  <= i_wdata;
          `SOTF_OFF_SOC_FINAL_WARN_FLAG_THR:  soc_final_warn_flag_thr_reg  <= i_wdata;
          `SOTF_OFF_DSG_THR:   dsg_thr_reg   <= i_wdata;
          `SOTF_OFF_INT_MASK:  int_mask_reg  <= i_wdata[5:0];
          `SOTF_OFF_ENERGY:    energy_reg    <= i_wdata;
          `SOTF_OFF_USER_RATE: user_rate_reg <= i_wdata;
          default: ;
        endcase
      end
      // Capacity tracking and warning flags
      if (i_cap_update) begin
        o_remaining_cap   <= rc_next;
        nom_reg           <= nom_next;
        o_nominal_avail_cap <= nom_next;
        o_full_avail_cap  <= i_full_unloaded;
        o_full_charge_cap <= (i_volt_mv > i_term_mv) ? i_full_loaded : o_full_charge_cap;
        if (rc_next < soc_initial_warn_flag_set)
          o_soc_initial_warn_flag <= 1'b1;
        else if (rc_next > soc_initial_warn_flag_clr)
          o_soc_initial_warn_flag <= 1'b0;
        if ((soc_final_warn_flag_set != `SOTF_SOC_FINAL_WARN_FLAG_OFF) && (rc_next < soc_final_warn_flag_set))
          o_soc_final_warn_flag <= 1'b1;
        else if (o_soc_final_warn_flag && (rc_next > soc_final_warn_flag_clr))
          o_soc_final_warn_flag <= 1'b0;
      end
      if (i_relaxed && i_short_detect)
        o_internal_short_flag <= 1'b1;
      if (i_two_cell_par && i_tab_detect)
        o_tab_disconnect_flag <= 1'b1;
      o_discharging <= (i_current < -dsg_thr);
      // Load model and options
      o_load_model_status_bit <= load_model;
      if (load_model)
        o_load_rate <= pick_rate(load_sel, user_rate_reg[CAP_W-1:0]);
      else
        o_load_rate <= pick_rate(load_sel, user_rate_reg[CAP_W-1:0]);
      o_reserve_cap <= reserve_comp_select ? i_reserve_loaded : i_reserve_noload;
      o_scale_x10   <= cfg_reg[`SOTF_CFG_SCALE10];
      // Interrupt status: set wins over read clear
      if (i_rd && (i_addr == `SOTF_OFF_INT_STAT))
        int_stat_reg <= soc_evt;
      else
        int_stat_reg <= int_stat_reg | soc_evt;
      o_irq <= |((int_stat_reg | soc_evt) & int_mask_reg &
                 ~((i_rd && (i_addr == `SOTF_OFF_INT_STAT)) ? int_stat_reg : 6'h00));
      // Register reads
      if (i_rd) begin
        case (i_addr)
          `SOTF_OFF_CFG:       o_rdata <= cfg_reg;
          `SOTF_OFF_SOC_INITIAL_WARN_FLAG_THR:  o_rdata <= soc_initial_warn_flag_thr_reg;
          `SOTF_OFF_SOC_FINAL_WARN_FLAG_THR:  o_rdata <= soc_final_warn_flag_thr_reg;
          `SOTF_OFF_DSG_THR:   o_rdata <= dsg_thr_reg;
          `SOTF_OFF_FLAGS:     o_rdata <= {26'h0, o_load_model_status_bit, o_discharging,
                                           o_tab_disconnect_flag, o_internal_short_flag,
                                           o_soc_final_warn_flag, o_soc_initial_warn_flag};
          `SOTF_OFF_CAP:       o_rdata <= {o_full_charge_cap, o_remaining_cap};
          `SOTF_OFF_LOAD:      o_rdata <= {o_reserve_cap, o_load_rate};
          `SOTF_OFF_INT_STAT:  o_rdata <= {26'h0, int_stat_reg};
          `SOTF_OFF_INT_MASK:  o_rdata <= {26'h0, int_mask_reg};
          `SOTF_OFF_ENERGY:    o_rdata <= energy_reg;
          `SOTF_OFF_USER_RATE: o_rdata <= user_rate_reg;
          default:             o_rdata <= 32'h0000_0000;
        endcase
      end else begin
        o_rdata <= 32'h0000_0000;
      end
    end
  end

endmodule // sotf_core
`default_nettype wire

// File: sotf_core_properties.sv
// Checker on the ports of the warning flag and load model core.
// Assumes the core's register offsets and reset thresholds.
`timescale 1ns/1ps
`default_nettype none
module sotf_core_properties #(
  parameter CAP_W = 16
) (
  input wire logic             i_clk,
  input wire logic             i_reset,
  input wire logic [3:0]       i_addr,
  input wire logic [31:0]      i_wdata,
  input wire logic             i_wr,
  input wire logic             i_rd,
  input wire logic [31:0]      o_rdata,
  input wire logic             i_cap_update,
  input wire logic [CAP_W-1:0] o_remaining_cap,
  input wire logic             o_soc_initial_warn_flag,
  input wire logic             o_soc_final_warn_flag,
  input wire logic             o_internal_short_flag,
  input wire logic             o_tab_disconnect_flag,
  input wire logic             o_load_model_status_bit,
  input wire logic             o_scale_x10
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [15:0] set1_reg, clr1_reg;
  logic        off_reg;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      set1_reg <= 16'h00c8;
      clr1_reg <= 16'h0096;
      off_reg <= 1'b0;
    end else if (i_wr && i_addr == 4'h1) begin
      set1_reg <= i_wdata[15:0];
      clr1_reg <= i_wdata[31:16];
    end else if (i_wr && i_addr == 4'h2) begin
      off_reg <= (i_wdata[15:0] == 16'hffff);
    end
  end
  property p_hold; !$past(i_cap_update) |-> $stable(o_soc_initial_warn_flag); endproperty
  a_hold: assert property (p_hold) else $error("flag moved without update");
  property p_set1; $rose(o_soc_initial_warn_flag) |-> o_remaining_cap < set1_reg; endproperty
  a_set1: assert property (p_set1) else $error("initial set early");
  property p_clr1; $fell(o_soc_initial_warn_flag) |-> o_remaining_cap > clr1_reg; endproperty
  a_clr1: assert property (p_clr1) else $error("initial clear early");
  property p_off; off_reg ##1 off_reg |-> !$rose(o_soc_final_warn_flag); endproperty
  a_off: assert property (p_off) else $error("final set while disabled");
  property p_load_model_status_bit; i_wr && i_addr == 4'h0 |-> ##2 o_load_model_status_bit == $past(i_wdata[0], 2); endproperty
  a_load_model_status_bit: assert property (p_load_model_status_bit) else $error("mode bit wrong");
  property p_scale; i_wr && i_addr == 4'h0 |-> ##2 o_scale_x10 == $past(i_wdata[2], 2); endproperty
  a_scale: assert property (p_scale) else $error("scale bit wrong");
  property p_short; o_internal_short_flag |=> o_internal_short_flag; endproperty
  a_short: assert property (p_short) else $error("short flag dropped");
  property p_tab; o_tab_disconnect_flag |=> o_tab_disconnect_flag; endproperty
  a_tab: assert property (p_tab) else $error("tab flag dropped");
  property p_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer");
  c_set1: cover property ($rose(o_soc_initial_warn_flag));
  c_fin: cover property ($fell(o_soc_final_warn_flag));
  c_short: cover property ($rose(o_internal_short_flag));
endmodule // sotf_core_properties
bind sotf_core sotf_core_properties #(.CAP_W(CAP_W)) sotf_core_properties_i (.*);
`default_nettype wire

// File: sotf_core_tb.sv
// Self-checking bench for the warning flag and load model core.
// Assumes the host model for register traffic and a 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module sotf_core_tb;
  logic i_clk = 0, i_reset = 1, i_wr, i_rd, i_cap_update = 0, i_relaxed = 0, i_short_detect = 0;
  logic i_two_cell_par = 0, i_tab_detect = 0, o_soc_initial_warn_flag, o_soc_final_warn_flag;
  logic o_internal_short_flag, o_tab_disconnect_flag, o_discharging, o_load_model_status_bit, o_scale_x10, o_irq;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata, r, lf = 32'h71fc1853;
  logic signed [15:0] i_charge_delta = 0, i_current = 0;
  logic [15:0] i_full_loaded = 16'h0aaa, i_full_unloaded = 16'h0bbb, i_volt_mv = 16'h3000, i_term_mv = 16'h2000;
  logic [15:0] i_reserve_loaded = 16'h0111, i_reserve_noload = 16'h0222, i_rate_prev = 16'h1000;
  logic [15:0] i_rate_present = 16'h1001, i_rate_avg = 16'h1002, i_rate_filt = 16'h1003, i_rate_design5 = 16'h1004;
  logic [15:0] i_forecast_rate_value = 16'h1005, o_remaining_cap, o_full_charge_cap, o_nominal_avail_cap;
  logic [15:0] o_full_avail_cap, o_load_rate, o_reserve_cap, setf = 16'h0032;
  int errors = 0, check_count = 0, cyc = 0, rc = 0, d, k, m, s;
  bit f1 = 0, ff = 0;
  always #10 i_clk = ~i_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  sotf_core sotf_core_i (.*);
  sotf_host_model sotf_host_model_i (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));
  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic upd(input int dl);
    @(posedge i_clk);
    i_cap_update <= 1'b1;
    i_charge_delta <= dl[15:0];
    @(posedge i_clk);
    i_cap_update <= 1'b0;
    rc = rc + dl;
    rc = rc < 0 ? 0 : (rc > 65535 ? 65535 : rc);
    if (rc < 300) f1 = 1;
    else if (rc > 400) f1 = 0;
    if (rc < setf && setf != 16'hffff) ff = 1;
    else if (ff && rc > 100) ff = 0;
    @(posedge i_clk);
    #1;
    chk(o_remaining_cap === rc[15:0], "remaining");
    chk(o_nominal_avail_cap === rc[15:0], "nominal");
    chk(o_soc_initial_warn_flag === f1, "initial flag");
    chk(o_soc_final_warn_flag === ff, "final flag");
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    sotf_host_model_i.wr(4'h8, 32'h1f);
    sotf_host_model_i.wr(4'h1, {16'd400, 16'd300});
    for (k = 0; k < 90; k++) begin
      lf = lfsr(lf);
      d = 20 + lf[4:0];
      if ((k >= 20 && k < 45) || k >= 65) d = -d;
      if (k == 65) sotf_host_model_i.wr(4'h2, {16'd100, 16'hffff});
      if (k == 65) setf = 16'hffff;
      upd(d);
    end
    chk(o_irq === 1'b1, "irq raised");
    sotf_host_model_i.rd(4'h7, r);
    chk(r[0] === 1'b1, "status bit");
    sotf_host_model_i.rd(4'h4, r);
    chk(r[1:0] === {ff, f1}, "flags word");
    sotf_host_model_i.rd(4'hf, r);
    chk(r === 32'h0, "unmapped");
    chk(o_irq === 1'b0, "irq cleared");
    chk(o_full_charge_cap === 16'h0aaa && o_full_avail_cap === 16'h0bbb, "full caps");
    i_volt_mv <= 16'h1000;
    i_full_loaded <= 16'h0ccc;
    upd(0);
    chk(o_full_charge_cap === 16'h0aaa, "full held");
    sotf_host_model_i.wr(4'ha, 32'h1006);
    for (m = 0; m < 2; m++) for (s = 0; s < 8; s++) begin
      sotf_host_model_i.wr(4'h0, {25'h0, s[2:0], 1'b0, s[0], s[1], m[0]});
      upd(0);
      chk(o_load_rate === 16'h1000 + 16'(s > 6 ? 6 : s), "load rate");
      chk(o_load_model_status_bit === m[0] && o_scale_x10 === s[0], "mode bits");
      chk(o_reserve_cap === (s[1] ? 16'h0111 : 16'h0222), "reserve");
    end
    i_tab_detect <= 1'b1;
    upd(0);
    chk(o_tab_disconnect_flag === 1'b0, "tab single cell");
    {i_two_cell_par, i_relaxed, i_short_detect} <= 3'h7;
    upd(0);
    {i_tab_detect, i_short_detect} <= 2'h0;
    upd(0);
    chk(o_tab_disconnect_flag === 1'b1 && o_internal_short_flag === 1'b1, "fault flags");
    i_current <= -16'sd60;
    upd(0);
    chk(o_discharging === 1'b0, "no discharge");
    i_current <= -16'sd61;
    upd(0);
    chk(o_discharging === 1'b1, "discharge");
    summarize();
  end
endmodule // sotf_core_tb
`default_nettype wire

// File: sotf_host_model.sv
// Host on the register port: one-cycle write and read strobes.
// Assumes the bench calls wr and rd in sequence from one process.
`timescale 1ns/1ps
`default_nettype none
module sotf_host_model (
  // Clock and answer
  input  wire logic        i_clk,
  input  wire logic [31:0] i_rdata,
  // Register requests
  output var  logic [3:0]  o_addr,
  output var  logic [31:0] o_wdata,
  output var  logic        o_wr,
  output var  logic        o_rd
);
  initial begin
    o_addr = 4'h0;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Scale bit only selects x1 or x10, never another scale
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask
endmodule // sotf_host_model
`default_nettype wire
